//--- hw/casr_pkg.sv
// Package for the codec analog status and configuration register bank.
// Assumes a single 100 MHz clock and an AHB-Lite slave with 32-bit data.
`default_nettype none

package casr_pkg;

  // ---------------------------------------------------------------
  // Register indices; the byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [7:0] PAGE_SELECT_IDX = 8'h00;
  localparam logic [7:0] GAIN_FLAGS_IDX = 8'h3F;
  localparam logic [7:0] RSVD_LOW_FIRST_IDX = 8'h40;
  localparam logic [7:0] QUICK_CHARGE_IDX = 8'h47;
  localparam logic [7:0] RSVD_HIGH_FIRST_IDX = 8'h48;
  localparam logic [7:0] REF_POWERUP_IDX = 8'h7B;
  localparam logic [7:0] CHARGE_PUMP_IDX = 8'h7C;
  localparam logic [7:0] IRQ_STATUS_IDX = 8'h7E;
  localparam logic [7:0] IRQ_MASK_IDX = 8'h7F;
  localparam logic [7:0] CFG_PAGE = 8'h01;

  // ---------------------------------------------------------------
  // Field positions and masks
  // ---------------------------------------------------------------
  localparam logic [7:0] QUICK_CHARGE_MASK = 8'h3F;
  localparam logic [7:0] REF_POWERUP_MASK = 8'h07;
  localparam logic [7:0] CHARGE_PUMP_MASK = 8'hFF;
  localparam int REF_FORCE_BIT = 2;
  localparam int CP_LOAD_LSB = 4;
  localparam int CP_DIV_LSB = 0;

  // ---------------------------------------------------------------
  // Reset values and codes
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [5:0] PUT_3P1MS = 6'h31;
  localparam logic [5:0] PUT_6P4MS = 6'h32;
  localparam logic [5:0] PUT_1P6MS = 6'h33;
  localparam logic [3:0] CP_DIV_ZERO_FACTOR = 4'h0;
  localparam logic [6:0] CP_DIV_ZERO_RATIO = 7'h40;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int PUT_3P1_US = 3100;
  localparam int PUT_6P4_US = 6400;
  localparam int PUT_1P6_US = 1600;
  localparam int REF_40_MS = 40;
  localparam int REF_80_MS = 80;
  localparam int REF_120_MS = 120;
  localparam int REF_SLOW_MS = 200;
  localparam int PUT_3P1_CYC = PUT_3P1_US * CLK_MHZ;
  localparam int PUT_6P4_CYC = PUT_6P4_US * CLK_MHZ;
  localparam int PUT_1P6_CYC = PUT_1P6_US * CLK_MHZ;
  localparam int REF_40_CYC = REF_40_MS * 1000 * CLK_MHZ;
  localparam int REF_80_CYC = REF_80_MS * 1000 * CLK_MHZ;
  localparam int REF_120_CYC = REF_120_MS * 1000 * CLK_MHZ;
  localparam int REF_SLOW_CYC = REF_SLOW_MS * 1000 * CLK_MHZ;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {RefOff, RefRamping, RefReady} casr_ref_e;

  typedef struct packed {
    logic [7:0] leftHeadphoneDriver;
    logic [7:0] rightHeadphoneDriver;
    logic [7:0] leftLineOutput;
    logic [7:0] rightLineOutput;
    logic [7:0] leftInputOneBypass;
    logic [7:0] rightInputOneBypass;
    logic [7:0] leftMixerAmplifier;
    logic [7:0] rightMixerAmplifier;
  } casr_gain_s;

endpackage

`default_nettype wire

//--- hw/casr_regs.sv
// Codec analog status and configuration register bank, AHB-Lite slave.
// Assumes gain ramps are tracked elsewhere and report applied and programmed values.
// Operation
// RULE_01 - Bits 7,6 flag left/right headphone driver applied gain equals programmed.
// RULE_02 - Bits 5,4 flag left/right line output applied gain equals programmed.
// RULE_03 - Bits 3,2 flag left/right input one bypass volume settled.
// RULE_04 - Bits 1,0 flag left/right mixer amplifier volume settled.
// RULE_05 - Flag register is read-only and reads zero after reset.
// RULE_06 - Software writes zero to reserved locations; they read back zero.
// RULE_07 - Input power-up code 0x31 3.1 ms, 0x32 6.4 ms, 0x33 1.6 ms.
// RULE_08 - Power-up field resets to zero; software uses only defined codes.
// RULE_09 - Reference bit 2 clear: follows analog power; set: forced on.
// RULE_10 - Reference low bits pick slow, 40, 80 or 120 ms ramp.
// RULE_11 - Charge pump load field: 0 full, N means N/8 peak.
// RULE_12 - Charge pump divider is four times field, zero divides by 64.
// RULE_13 - Index 0 on every page selects the page for later accesses.
// RULE_14 - Flags follow ramp state continuously; reads do not alter them.
//
// The AHB-Lite interface to the registers is this design's own decision.
`default_nettype none

module casr_regs
  import casr_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Ramp state from the analog gain controls
  input wire casr_gain_s appliedGain,
  input wire casr_gain_s programmedGain,
  input wire logic analogPowerUp,
  // Analog configuration outputs
  output logic [5:0] inputPowerUpTime,
  output logic inputsReady,
  output logic referencePowered,
  output logic referenceReady,
  output logic [2:0] chargePumpLoad,
  output logic [6:0] chargePumpDivide,
  output logic [7:0] pageSelect,
  // Interrupt
  output logic irq
);

  // ---------------------------------------------------------------
  // Bus address phase capture
  // ---------------------------------------------------------------
  logic wrPend_q;
  logic rdPend_q;
  logic [7:0] regIdx_q;
  logic [7:0] pageSel_q;
  logic [7:0] quickCharge_q;
  logic [7:0] refCfg_q;
  logic [7:0] cpCtrl_q;
  logic [7:0] flags_q;
  logic [7:0] irqStatus_q;
  logic [7:0] irqMask_q;
  logic [7:0] wByte;
  logic onCfgPage;
  logic wrPage;
  logic wrCfg;
  logic [7:0] rdVal;
  logic [7:0] flagsNow;
  logic [7:0] flagsPrev_q;

  wire addrValid = hsel && hready && htrans[1];

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wrPend_q <= 1'b0;
      rdPend_q <= 1'b0;
      regIdx_q <= 8'h00;
    end else begin
      wrPend_q <= addrValid && hwrite;
      rdPend_q <= addrValid && !hwrite;
      if (addrValid) begin
        regIdx_q <= haddr[9:2];
      end
    end
  end

  assign wByte = hwdata[7:0];
  assign onCfgPage = (pageSel_q == CFG_PAGE);
  assign wrPage = wrPend_q && (regIdx_q == PAGE_SELECT_IDX);
  assign wrCfg = wrPend_q && onCfgPage;

  // ---------------------------------------------------------------
  // Page select, present on every page
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pageSel_q <= REG_RESET;
    end else if (wrPage) begin
      pageSel_q <= wByte; // [RULE_13]
    end
  end

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  // Reserved bits are masked so they always read zero, except bit 7 of the charge pump register, which is stored
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      quickCharge_q <= REG_RESET; // [RULE_08]
      refCfg_q <= REG_RESET;
      cpCtrl_q <= REG_RESET;
      irqMask_q <= REG_RESET;
    end else if (wrCfg) begin
      unique case (regIdx_q)
        QUICK_CHARGE_IDX: quickCharge_q <= wByte & QUICK_CHARGE_MASK; // [RULE_06]
        REF_POWERUP_IDX: refCfg_q <= wByte & REF_POWERUP_MASK; // [RULE_06]
        CHARGE_PUMP_IDX: cpCtrl_q <= wByte & CHARGE_PUMP_MASK;
        IRQ_MASK_IDX: irqMask_q <= wByte;
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Settle flags, sampled every cycle
  // ---------------------------------------------------------------
  // Applied versus programmed compare per channel
  for (genvar i = 0; i < 8; i++) begin : gFlag
    assign flagsNow[i] = (appliedGain[8*i +: 8] == programmedGain[8*i +: 8]); // [RULE_01] [RULE_02] [RULE_03] [RULE_04]
  end

  // Reads never touch these; they only follow the ramps
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      flags_q <= REG_RESET; // [RULE_05]
      flagsPrev_q <= REG_RESET;
    end else begin
      flags_q <= flagsNow; // [RULE_14]
      flagsPrev_q <= flags_q;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt status: a flag that settles raises its bit
  // ---------------------------------------------------------------
  wire [7:0] settleEvt = flags_q & ~flagsPrev_q;
  wire [7:0] w1cClear = (wrCfg && regIdx_q == IRQ_STATUS_IDX) ? wByte : 8'h00;

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irqStatus_q <= REG_RESET;
      irq <= 1'b0;
    end else begin
      irqStatus_q <= (irqStatus_q & ~w1cClear) | settleEvt;
      irq <= |(((irqStatus_q & ~w1cClear) | settleEvt) & irqMask_q);
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  always_comb begin
    rdVal = 8'h00; // [RULE_06]
    if (regIdx_q == PAGE_SELECT_IDX) begin
      rdVal = pageSel_q;
    end else if (onCfgPage) begin
      unique case (regIdx_q)
        GAIN_FLAGS_IDX: rdVal = flags_q;
        QUICK_CHARGE_IDX: rdVal = quickCharge_q;
        REF_POWERUP_IDX: rdVal = refCfg_q;
        CHARGE_PUMP_IDX: rdVal = cpCtrl_q;
        IRQ_STATUS_IDX: rdVal = irqStatus_q;
        IRQ_MASK_IDX: rdVal = irqMask_q;
        default: rdVal = 8'h00;
      endcase
    end
  end

  // Data registered one edge after the address phase edge so hrdata is a flop
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= !(addrValid && !hwrite);
      hresp <= 1'b0;
      hrdata <= rdPend_q ? {24'h00_0000, rdVal} : 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------
  // Analog input power-up timer
  // ---------------------------------------------------------------
  // Undefined codes hold the inputs unready until the count reaches 0xFFFF_FFFF; software must avoid them
  // Counts run to hundreds of thousands of cycles, far beyond what a short bench can wait
  logic [31:0] putCount_q;
  logic [31:0] putTarget;
  always_comb begin
    unique case (quickCharge_q[5:0])
      PUT_3P1MS: putTarget = 32'(PUT_3P1_CYC); // [RULE_07]
      PUT_6P4MS: putTarget = 32'(PUT_6P4_CYC); // [RULE_07]
      PUT_1P6MS: putTarget = 32'(PUT_1P6_CYC); // [RULE_07]
      default: putTarget = 32'hFFFF_FFFF;
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      putCount_q <= 32'h0000_0000;
      inputsReady <= 1'b0;
      inputPowerUpTime <= 6'h00;
    end else begin
      inputPowerUpTime <= quickCharge_q[5:0];
      if (!analogPowerUp) begin
        putCount_q <= 32'h0000_0000;
        inputsReady <= 1'b0;
      end else if (putCount_q < putTarget) begin
        putCount_q <= putCount_q + 32'h0000_0001;
        inputsReady <= 1'b0;
      end else begin
        inputsReady <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Reference power-up sequencer
  // ---------------------------------------------------------------
  casr_ref_e refState_q;
  logic [31:0] refCount_q;
  logic [31:0] refTarget;
  wire refWanted = refCfg_q[REF_FORCE_BIT] || analogPowerUp; // [RULE_09]

  always_comb begin
    unique case (refCfg_q[1:0])
      2'b00: refTarget = 32'(REF_SLOW_CYC); // [RULE_10]
      2'b01: refTarget = 32'(REF_40_CYC); // [RULE_10]
      2'b10: refTarget = 32'(REF_80_CYC); // [RULE_10]
      2'b11: refTarget = 32'(REF_120_CYC); // [RULE_10]
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      refState_q <= RefOff;
      refCount_q <= 32'h0000_0000;
      referencePowered <= 1'b0;
      referenceReady <= 1'b0;
    end else begin
      referencePowered <= refWanted;
      referenceReady <= (refState_q == RefReady) && refWanted;
      unique case (refState_q)
        RefOff: begin
          refCount_q <= 32'h0000_0000;
          if (refWanted) begin
            refState_q <= RefRamping;
          end
        end
        RefRamping: begin
          if (!refWanted) begin
            refState_q <= RefOff;
          end else if (refCount_q >= refTarget) begin
            refState_q <= RefReady;
          end else begin
            refCount_q <= refCount_q + 32'h0000_0001;
          end
        end
        RefReady: begin
          if (!refWanted) begin
            refState_q <= RefOff;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Charge pump settings
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      chargePumpLoad <= 3'h0;
      chargePumpDivide <= CP_DIV_ZERO_RATIO;
      pageSelect <= 8'h00;
    end else begin
      pageSelect <= pageSel_q;
      chargePumpLoad <= cpCtrl_q[CP_LOAD_LSB +: 3]; // [RULE_11]
      if (cpCtrl_q[CP_DIV_LSB +: 4] == CP_DIV_ZERO_FACTOR) begin
        chargePumpDivide <= CP_DIV_ZERO_RATIO; // [RULE_12]
      end else begin
        chargePumpDivide <= {1'b0, cpCtrl_q[CP_DIV_LSB +: 4], 2'b00}; // [RULE_12]
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  flags_follow_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE_01]
    $past(reset_n) |-> flags_q == $past(flagsNow)) else $error("settle flags lag wrong");
  flag_read_only_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE_05]
    (wrCfg && regIdx_q == GAIN_FLAGS_IDX) |=> flags_q == $past(flagsNow))
    else $error("flag write took effect");
  reserved_zero_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE_06]
    (rdPend_q && onCfgPage && regIdx_q > GAIN_FLAGS_IDX && regIdx_q < QUICK_CHARGE_IDX) |=> hrdata == 32'h0)
    else $error("reserved read not zero");
  ref_forced_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE_09]
    refCfg_q[REF_FORCE_BIT] |=> referencePowered) else $error("forced reference off");
  cp_div_zero_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE_12]
    (cpCtrl_q[3:0] == 4'h0) |=> chargePumpDivide == 7'h40) else $error("divide by 64 missing");
  cp_load_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE_11]
    ##1 chargePumpLoad == $past(cpCtrl_q[6:4])) else $error("pump load wrong");
  page_write_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE_13]
    wrPage |=> pageSel_q == $past(wByte)) else $error("page select not taken");
  put_code_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE_07]
    (quickCharge_q[5:0] == 6'h33) |-> putTarget == 32'h0002_7100) else $error("1.6 ms count wrong");
  ref_time_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE_10]
    (refCfg_q[1:0] == 2'b01) |-> refTarget == 32'h003D_0900) else $error("40 ms count wrong");

  // Read answer: one wait state, then ready with only the low byte live
  sequence readTaken;
    addrValid && !hwrite;
  endsequence
  sequence readAnswered;
    !hreadyout ##1 (hreadyout && hrdata[31:8] == 24'h00_0000);
  endsequence
  read_wait_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE_06]
    readTaken |=> readAnswered) else $error("read answer wrong");

  // Interrupt, reference and page guards
  status_sticky_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE_14]
    (settleEvt != 8'h00) |=> (irqStatus_q & $past(settleEvt)) == $past(settleEvt))
    else $error("settle event lost");
  irq_level_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE_14]
    irq == |(irqStatus_q & $past(irqMask_q))) else $error("interrupt level wrong");
  ref_auto_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE_09]
    !refWanted |=> !referencePowered && !referenceReady) else $error("reference on without request");
  page_guard_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE_13]
    (wrPend_q && !onCfgPage) |=> $stable(cpCtrl_q) && $stable(refCfg_q)) else $error("write leaked off page");

endmodule

`default_nettype wire

//--- sim/tb_casr_regs.sv
// Self-checking bench for the codec analog status and configuration bank.
// Assumes one 100 MHz clock and the bank as sole AHB-Lite slave.
`default_nettype none

module tb_casr_regs import casr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic reset_n;
  logic hsel;
  logic hwrite;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic analogPowerUp;
  casr_gain_s appliedGain;
  casr_gain_s programmedGain;
  logic [5:0] inputPowerUpTime;
  logic inputsReady;
  logic referencePowered;
  logic referenceReady;
  logic irq;
  logic [2:0] chargePumpLoad;
  logic [6:0] chargePumpDivide;
  logic [7:0] pageSelect;
  logic [31:0] rdata;
  logic [7:0] rsvd [6] = '{8'h40, 8'h46, 8'h48, 8'h7A, 8'h7D, 8'hC0};
  int n_errors = 0;
  int total_checks = 0;
  int cycles = 0;

  always #5 clk_sys = ~clk_sys;

  casr_regs casr_regs_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .appliedGain(appliedGain),
    .programmedGain(programmedGain), .analogPowerUp(analogPowerUp),
    .inputPowerUpTime(inputPowerUpTime), .inputsReady(inputsReady),
    .referencePowered(referencePowered), .referenceReady(referenceReady),
    .chargePumpLoad(chargePumpLoad), .chargePumpDivide(chargePumpDivide),
    .pageSelect(pageSelect), .irq(irq)
  );

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Entered just after a rising edge; no wait count assumed
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    haddr <= {22'h000000, idx, 2'h0};
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    rdata = hrdata;
    hwdata <= 32'h00000000;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] val);
    bus(1'b1, idx, {24'h000000, val});
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 32'h00000000);
    check(rdata, {24'h000000, exp});
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
  endtask

  task automatic end_test(input string name);
    $display("test %s finished, mismatches so far %0d", name, n_errors);
  endtask

  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Hang guard, well above the few hundred cycles the run needs
  // ---------------------------------------------------------------
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, cycles, 0);
      test_done();
    end
  end

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    reset_n <= 1'b0;
    hsel <= 1'b0;
    hwrite <= 1'b0;
    htrans <= 2'h0;
    hsize <= 3'h2;
    haddr <= 32'h00000000;
    hwdata <= 32'h00000000;
    analogPowerUp <= 1'b0;
    appliedGain <= 64'h0000000000000000;
    programmedGain <= 64'h0102030405060708;
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    check(32'(chargePumpDivide), 32'h00000040);
    // Page 0 must not reach the bank
    wr(CHARGE_PUMP_IDX, 8'h55);
    rd(PAGE_SELECT_IDX, 8'h00);
    wr(PAGE_SELECT_IDX, CFG_PAGE);
    rd(PAGE_SELECT_IDX, CFG_PAGE);
    rd(CHARGE_PUMP_IDX, 8'h00);
    rd(GAIN_FLAGS_IDX, 8'h00);
    rd(QUICK_CHARGE_IDX, 8'h00);
    rd(REF_POWERUP_IDX, 8'h00);
    end_test("reset");
    // Lanes settle one by one, right mixer first
    for (int i = 0; i < 8; i++) begin
      appliedGain[i*8 +: 8] <= programmedGain[i*8 +: 8];
      tick(3);
      rd(GAIN_FLAGS_IDX, 8'((2 << i) - 1));
      rd(GAIN_FLAGS_IDX, 8'((2 << i) - 1));
    end
    wr(GAIN_FLAGS_IDX, 8'h00);
    rd(GAIN_FLAGS_IDX, 8'hFF);
    appliedGain[63:56] <= 8'h00;
    tick(3);
    rd(GAIN_FLAGS_IDX, 8'h7F);
    end_test("flags");
    // Sticky status, mask, write-one-to-clear
    // A set mask bit lets its status bit reach the interrupt
    rd(IRQ_STATUS_IDX, 8'hFF);
    wr(IRQ_MASK_IDX, 8'hFF);
    tick(3);
    check(32'(irq), 32'h00000001);
    wr(IRQ_MASK_IDX, 8'h00);
    tick(3);
    check(32'(irq), 32'h00000000);
    wr(IRQ_STATUS_IDX, 8'h0F);
    rd(IRQ_STATUS_IDX, 8'hF0);
    wr(IRQ_STATUS_IDX, 8'hF0);
    rd(IRQ_STATUS_IDX, 8'h00);
    wr(IRQ_MASK_IDX, 8'h80);
    tick(3);
    check(32'(irq), 32'h00000000);
    appliedGain[63:56] <= programmedGain[63:56];
    tick(4);
    rd(IRQ_STATUS_IDX, 8'h80);
    check(32'(irq), 32'h00000001);
    end_test("irq");
    // Power-up time codes
    for (int k = 0; k < 3; k++) begin
      wr(QUICK_CHARGE_IDX, {2'h0, PUT_3P1MS + 6'(k)});
      tick(2);
      rd(QUICK_CHARGE_IDX, {2'h0, PUT_3P1MS + 6'(k)});
      check(32'(inputPowerUpTime), 32'(PUT_3P1MS + 6'(k)));
    end
    // Every reference code, with and without analog power
    for (int k = 0; k < 16; k++) begin
      analogPowerUp <= k[3];
      wr(REF_POWERUP_IDX, 8'(k[2:0]));
      tick(3);
      rd(REF_POWERUP_IDX, 8'(k[2:0]));
      check(32'(referencePowered), 32'(k[2] | k[3]));
      check(32'(referenceReady), 32'h00000000);
      check(32'(inputsReady), 32'h00000000);
    end
    // Every load and divider value
    for (int k = 0; k < 16; k++) begin
      wr(CHARGE_PUMP_IDX, {k[0], 3'(k), 4'(k)});
      tick(2);
      rd(CHARGE_PUMP_IDX, {k[0], 3'(k), 4'(k)});
      check(32'(chargePumpLoad), 32'(k[2:0]));
      check(32'(chargePumpDivide), (k == 0) ? 32'h00000040 : 32'(4 * k));
    end
    end_test("config");
    // Reserved and unmapped places read zero
    wr(8'h40, 8'h00);
    for (int k = 0; k < 6; k++) begin
      rd(rsvd[k], 8'h00);
    end
    wr(PAGE_SELECT_IDX, 8'h02);
    rd(PAGE_SELECT_IDX, 8'h02);
    check(32'(pageSelect), 32'h00000002);
    rd(CHARGE_PUMP_IDX, 8'h00);
    wr(PAGE_SELECT_IDX, CFG_PAGE);
    rd(CHARGE_PUMP_IDX, 8'hFF);
    check(32'(hresp), 32'h00000000);
    end_test("pages");
    test_done();
  end

endmodule

`default_nettype wire
